// File: logic/buck_seq_map.vh
`ifndef BUCK_SEQ_MAP_VH
`define BUCK_SEQ_MAP_VH

// ************************************************************
// Clock and timing
// ************************************************************
`define CLK_MHZ            200
`define RAMP_T0_US         500
`define RAMP_T1_US         770
`define RAMP_T2_US         1000
`define RAMP_T3_US         2000
`define EN_DELAY_US        10
`define SYNC_WIN_US        5
`define NONSYNC_CYCLES     3'h6

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_SETPOINT       3'h0
`define OFS_CTRL1          3'h1
`define OFS_CTRL2          3'h2
`define OFS_CTRL3          3'h3
`define OFS_STATUS         3'h4

// ************************************************************
// Field positions
// ************************************************************
`define CTRL1_FORCED_PWM_OPERATION_BIT     0
`define CTRL1_SPAN_LSB     1
`define CTRL1_NONSYNC_BIT  3
`define CTRL2_DUR_LSB      0
`define CTRL3_SOLO_BIT     0

// ************************************************************
// Reset values
// ************************************************************
`define RST_CTRL1          8'h04
`define RST_CTRL2          8'h02
`define RST_CTRL3          8'h00
`define SETPT_STRAP0       8'h50
`define SETPT_STRAP1       8'h46
`define SETPT_STRAP2       8'h5f
`define SETPT_STRAP3       8'h24

// ************************************************************
// Operating modes
// ************************************************************
`define OP_OFF             2'h0
`define OP_CCM             2'h1
`define OP_DCM             2'h2
`define OP_PFM             2'h3

`endif

// File: logic/buck_seq_ctrl.v
// Functional notes
// RULE_01 - Mode from sync pin and forced PWM bit
// RULE_02 - Forced PWM continuous fixed frequency after ramp
// RULE_03 - Power save picks CCM, DCM, skipping by load
// RULE_04 - Skipped pulses aligned to switching clock
// RULE_05 - Load release: low side off six cycles
// RULE_06 - Hold enable low until defaults and straps
// RULE_07 - Faults pull enable low unless standalone
// RULE_08 - Standalone: no fault pulldown, init still holds
// RULE_09 - Stack controller keeps standalone bit zero
// RULE_10 - Shared enable: stack waits, one fault stops
// RULE_11 - Ready: release pulldown, enable pin is input
// RULE_12 - Register access opens when init completes
// RULE_13 - Enable low: switches off, control disabled
// RULE_14 - Init order: hold, reference, straps, defaults
// RULE_15 - Idle registers usable; ramp after short delay
// RULE_16 - Ramp duration field picks four ramp times
// RULE_17 - Updates during ramp deferred until ramp end
// RULE_18 - Prebiased start: switch once ramp exceeds output
// RULE_19 - Ramp allows DCM and skipping always
// RULE_20 - Duration codes ascending, reset code 10
// RULE_21 - Ramp complete flag releases held updates
//
// Added by the designer: strobed register access and the register addresses.
`include "buck_seq_map.vh"

module buck_seq_ctrl #(
   parameter RAMP_CYC0    = `RAMP_T0_US * `CLK_MHZ,
   parameter RAMP_CYC1    = `RAMP_T1_US * `CLK_MHZ,
   parameter RAMP_CYC2    = `RAMP_T2_US * `CLK_MHZ,
   parameter RAMP_CYC3    = `RAMP_T3_US * `CLK_MHZ,
   parameter EN_DELAY_CYC = `EN_DELAY_US * `CLK_MHZ,
   parameter SYNC_WIN_CYC = `SYNC_WIN_US * `CLK_MHZ
) (
   input  wire       clk_sys_i,
   input  wire       rst_i,
   input  wire [2:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   output reg  [7:0] reg_rdata_o,
   input  wire       en_pin_i,
   output wire       en_pin_o,
   output wire       en_pin_oe_o,
   input  wire       mode_sync_pin_i,
   input  wire [1:0] setpoint_strap_pin_i,
   input  wire [1:0] frequency_strap_pin_i,
   input  wire       clkout_strap_pin_i,
   input  wire       ref_ready_i,
   input  wire       thermal_fault_i,
   input  wire       overvolt_fault_i,
   input  wire       sw_tick_i,
   input  wire [1:0] load_level_i,
   input  wire       pfm_demand_i,
   input  wire       load_release_i,
   input  wire       ramp_above_out_i,
   output reg        ref_enable_o,
   output reg  [1:0] freq_sel_o,
   output reg        clkout_sel_o,
   output reg  [1:0] op_mode_o,
   output reg        switch_pulse_o,
   output reg        lowside_en_o,
   output reg        ramp_active_o,
   output reg  [7:0] active_setpoint_o,
   output reg  [1:0] active_span_o
);

   // ************************************************************
   // Local constants
   // ************************************************************
   localparam S_HOLD  = 2'h0;
   localparam S_STRAP = 2'h1;
   localparam S_LOAD  = 2'h2;
   localparam S_READY = 2'h3;

   localparam C_OFF   = 2'h0;
   localparam C_DELAY = 2'h1;
   localparam C_RAMP  = 2'h2;
   localparam C_RUN   = 2'h3;

   localparam [1:0] LOAD_VLOW = 2'h0;
   localparam [1:0] LOAD_LOW  = 2'h1;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   reg [1:0] en_meta_q;
   reg [1:0] mode_meta_q;
   reg [1:0] setpoint_strap_pin_meta_q;
   reg [1:0] setpoint_strap_pin_sync_q;
   reg [1:0] frequency_strap_pin_meta_q;
   reg [1:0] frequency_strap_pin_sync_q;
   reg [1:0] clko_meta_q;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         en_meta_q   <= 2'h0;
         mode_meta_q <= 2'h0;
         setpoint_strap_pin_meta_q <= 2'h0;
         setpoint_strap_pin_sync_q <= 2'h0;
         frequency_strap_pin_meta_q <= 2'h0;
         frequency_strap_pin_sync_q <= 2'h0;
         clko_meta_q <= 2'h0;
      end else begin
         en_meta_q   <= {en_meta_q[0], en_pin_i};
         mode_meta_q <= {mode_meta_q[0], mode_sync_pin_i};
         setpoint_strap_pin_meta_q <= setpoint_strap_pin_i;
         setpoint_strap_pin_sync_q <= setpoint_strap_pin_meta_q;
         frequency_strap_pin_meta_q <= frequency_strap_pin_i;
         frequency_strap_pin_sync_q <= frequency_strap_pin_meta_q;
         clko_meta_q <= {clko_meta_q[0], clkout_strap_pin_i};
      end
   end

   wire en_sync   = en_meta_q[1];
   wire mode_sync = mode_meta_q[1];

   // ************************************************************
   // Power-up initialisation
   // ************************************************************
   reg [1:0] init_q;
   reg [7:0] strap_setpt_q;
   wire      init_done = (init_q == S_READY);

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         init_q        <= S_HOLD;
         ref_enable_o  <= 1'b0;
         freq_sel_o    <= 2'h0;
         clkout_sel_o  <= 1'b0;
         strap_setpt_q <= `SETPT_STRAP0;
      end else begin
         case (init_q)
            S_HOLD: begin
               ref_enable_o <= 1'b1;                              // [RULE_14]
               // Extra hold cycle lets the strap synchronisers fill after reset
               if (ref_ready_i && ref_enable_o) begin
                  init_q <= S_STRAP;
               end
            end
            S_STRAP: begin
               freq_sel_o   <= frequency_strap_pin_sync_q;                       // [RULE_06] [RULE_14]
               clkout_sel_o <= clko_meta_q[1];
               case (setpoint_strap_pin_sync_q)
                  2'h0:    strap_setpt_q <= `SETPT_STRAP0;
                  2'h1:    strap_setpt_q <= `SETPT_STRAP1;
                  2'h2:    strap_setpt_q <= `SETPT_STRAP2;
                  default: strap_setpt_q <= `SETPT_STRAP3;
               endcase
               init_q <= S_LOAD;
            end
            S_LOAD: begin
               init_q <= S_READY;                                 // [RULE_14]
            end
            default: begin
               init_q <= S_READY;
            end
         endcase
      end
   end

   // ************************************************************
   // Register file
   // ************************************************************
   reg [7:0] setpoint_field_q;
   reg [7:0] ctrl1_q;
   reg [7:0] ctrl2_q;
   reg [7:0] ctrl3_q;
   reg       ramp_done_q;
   reg [1:0] conv_q;
   wire      fault = thermal_fault_i | overvolt_fault_i;

   wire       forced_pwm_bit      = ctrl1_q[`CTRL1_FORCED_PWM_OPERATION_BIT];
   wire [1:0] level_span_field    = ctrl1_q[`CTRL1_SPAN_LSB +: 2];
   wire       nonsync_bit         = ctrl1_q[`CTRL1_NONSYNC_BIT];
   wire [1:0] ramp_duration_field = ctrl2_q[`CTRL2_DUR_LSB +: 2];
   wire       standalone_bit      = ctrl3_q[`CTRL3_SOLO_BIT];

   // Access gated by init only, never by enable or ready
   wire bus_open = init_done;                                     // [RULE_12] [RULE_15]

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl1_q          <= `RST_CTRL1;
         ctrl2_q          <= `RST_CTRL2;                          // [RULE_20]
         ctrl3_q          <= `RST_CTRL3;
         setpoint_field_q <= `SETPT_STRAP0;
      end else if (init_q == S_LOAD) begin
         setpoint_field_q <= strap_setpt_q;                       // [RULE_14]
      end else if (bus_open && reg_wr_i) begin
         case (reg_addr_i)
            `OFS_SETPOINT: setpoint_field_q <= reg_wdata_i;
            `OFS_CTRL1:    ctrl1_q          <= reg_wdata_i & 8'h0f;
            `OFS_CTRL2:    ctrl2_q          <= reg_wdata_i & 8'h03;
            `OFS_CTRL3:    ctrl3_q          <= reg_wdata_i & 8'h01;
            default:       ctrl1_q          <= ctrl1_q;
         endcase
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (bus_open && reg_rd_i) begin
         case (reg_addr_i)
            `OFS_SETPOINT: reg_rdata_o <= setpoint_field_q;
            `OFS_CTRL1:    reg_rdata_o <= ctrl1_q;
            `OFS_CTRL2:    reg_rdata_o <= ctrl2_q;
            `OFS_CTRL3:    reg_rdata_o <= ctrl3_q;
            `OFS_STATUS:   reg_rdata_o <= {op_mode_o, fault, ramp_done_q,
                                           (conv_q == C_RAMP), (conv_q != C_OFF),
                                           en_sync, init_done};
            default:       reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ************************************************************
   // Shared enable pin
   // ************************************************************
   // Open drain: only ever drives low, external pull-up gives high
   assign en_pin_o    = 1'b0;
   assign en_pin_oe_o = ~init_done |                              // [RULE_06] [RULE_08]
                        (fault & ~standalone_bit);                // [RULE_07] [RULE_09] [RULE_10]

   // Fault kills the local converter even when standalone
   wire enable = init_done & en_sync & ~fault;                    // [RULE_11] [RULE_10]

   // ************************************************************
   // Mode pin and external clock detection
   // ************************************************************
   reg        mode_prev_q;
   reg [10:0] sync_win_q;
   wire       sync_clk = (sync_win_q != 11'h000);

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         mode_prev_q <= 1'b0;
         sync_win_q  <= 11'h000;
      end else begin
         mode_prev_q <= mode_sync;
         if (mode_sync != mode_prev_q) begin
            sync_win_q <= SYNC_WIN_CYC[10:0];
         end else if (sync_clk) begin
            sync_win_q <= sync_win_q - 11'h001;
         end
      end
   end

   // Pin low, no sync clock and bit clear is the only power-save case
   wire power_save_operation = ~mode_sync & ~sync_clk & ~forced_pwm_bit;  // [RULE_01]

   // ************************************************************
   // Converter sequence and soft start
   // ************************************************************
   reg [18:0] cnt_q;
   reg [18:0] ramp_len;
   reg [1:0]  active_dur_q;

   always @* begin
      case (active_dur_q)                                         // [RULE_16] [RULE_20]
         2'h0:    ramp_len = RAMP_CYC0[18:0];
         2'h1:    ramp_len = RAMP_CYC1[18:0];
         2'h2:    ramp_len = RAMP_CYC2[18:0];
         default: ramp_len = RAMP_CYC3[18:0];
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         conv_q            <= C_OFF;
         cnt_q             <= 19'h00000;
         ramp_done_q       <= 1'b0;
         active_setpoint_o <= `SETPT_STRAP0;
         active_span_o     <= 2'h2;
         active_dur_q      <= 2'h2;
      end else if (!enable) begin
         conv_q            <= C_OFF;                              // [RULE_13]
         cnt_q             <= 19'h00000;
         ramp_done_q       <= 1'b0;
         active_setpoint_o <= setpoint_field_q;                   // [RULE_15]
         active_span_o     <= level_span_field;
         active_dur_q      <= ramp_duration_field;
      end else begin
         case (conv_q)
            C_OFF: begin
               conv_q <= C_DELAY;
               cnt_q  <= 19'h00000;
            end
            C_DELAY: begin
               if (cnt_q >= EN_DELAY_CYC[18:0] - 19'h00001) begin  // [RULE_15]
                  conv_q <= C_RAMP;
                  cnt_q  <= 19'h00000;
               end else begin
                  cnt_q <= cnt_q + 19'h00001;
               end
            end
            C_RAMP: begin
               // Shadow values frozen for the whole ramp
               if (cnt_q >= ramp_len - 19'h00001) begin           // [RULE_17] [RULE_18]
                  conv_q      <= C_RUN;
                  ramp_done_q <= 1'b1;                            // [RULE_21]
               end else begin
                  cnt_q <= cnt_q + 19'h00001;
               end
            end
            default: begin
               active_setpoint_o <= setpoint_field_q;             // [RULE_17] [RULE_21]
               active_span_o     <= level_span_field;
               active_dur_q      <= ramp_duration_field;
            end
         endcase
      end
   end

   // ************************************************************
   // Operating mode and switching
   // ************************************************************
   reg [1:0] load_mode;
   reg [2:0] nonsync_cnt_q;
   reg       release_prev_q;
   wire      ramping   = (conv_q == C_RAMP);
   // Prebiased output: hold switching until ramp passes it
   wire      switching = (conv_q == C_RUN) | (ramping & ramp_above_out_i);  // [RULE_18]

   always @* begin
      case (load_level_i)                                         // [RULE_03]
         LOAD_VLOW: load_mode = `OP_PFM;
         LOAD_LOW:  load_mode = `OP_DCM;
         default:   load_mode = `OP_CCM;
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         release_prev_q <= 1'b0;
         nonsync_cnt_q  <= 3'h0;
      end else begin
         release_prev_q <= load_release_i;
         if (!switching) begin
            nonsync_cnt_q <= 3'h0;
         end else if (load_release_i && !release_prev_q && nonsync_bit) begin
            nonsync_cnt_q <= `NONSYNC_CYCLES;                     // [RULE_05]
         end else if (sw_tick_i && nonsync_cnt_q != 3'h0) begin
            nonsync_cnt_q <= nonsync_cnt_q - 3'h1;
         end
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         op_mode_o      <= `OP_OFF;
         switch_pulse_o <= 1'b0;
         lowside_en_o   <= 1'b0;
         ramp_active_o  <= 1'b0;
      end else begin
         ramp_active_o <= ramping;
         if (!switching) begin
            op_mode_o      <= `OP_OFF;                            // [RULE_13]
            switch_pulse_o <= 1'b0;
            lowside_en_o   <= 1'b0;
         end else begin
            if (ramping || power_save_operation) begin
               op_mode_o <= load_mode;                            // [RULE_19] [RULE_03]
            end else begin
               op_mode_o <= `OP_CCM;                              // [RULE_02]
            end
            // Pulses only on the switching clock tick
            switch_pulse_o <= sw_tick_i &                         // [RULE_04]
                              ((op_mode_o != `OP_PFM) | pfm_demand_i);
            lowside_en_o   <= (nonsync_cnt_q == 3'h0);            // [RULE_05]
         end
      end
   end

endmodule

// File: verif/buck_seq_chk_sva.sv
`include "buck_seq_map.vh"
module buck_seq_chk #(
   parameter RAMP_CYC0 = 100000,
   parameter RAMP_CYC1 = 154000,
   parameter RAMP_CYC2 = 200000,
   parameter RAMP_CYC3 = 400000
) (
   input logic       clk_sys_i,
   input logic       rst_i,
   input logic       reg_rd_i,
   input logic [7:0] reg_rdata_o,
   input logic       en_pin_oe_o,
   input logic       mode_sync_pin_i,
   input logic       thermal_fault_i,
   input logic       overvolt_fault_i,
   input logic       sw_tick_i,
   input logic [1:0] load_level_i,
   input logic       ref_enable_o,
   input logic [1:0] op_mode_o,
   input logic       switch_pulse_o,
   input logic       lowside_en_o,
   input logic       ramp_active_o,
   input logic [7:0] active_setpoint_o,
   input logic [1:0] active_span_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // Counter, not a repetition: ramps run far past eight cycles
   logic [19:0] ramp_cnt_q;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !ramp_active_o) begin
         ramp_cnt_q <= 20'h0;
      end else begin
         ramp_cnt_q <= ramp_cnt_q + 20'h1;
      end
   end
   sequence init_hold_s;
      en_pin_oe_o [*2];
   endsequence
   sequence sync_high_s;
      mode_sync_pin_i [*4] ##0 !ramp_active_o ##0 op_mode_o != `OP_OFF;
   endsequence
   init_hold_a: assert property ($fell(rst_i) |-> init_hold_s)
      else $error("enable pin released during init");
   ref_first_a: assert property ($fell(rst_i) |-> ##[0:2] ref_enable_o)
      else $error("reference not started first");
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside read slot");
   fault_off_a: assert property ((thermal_fault_i || overvolt_fault_i)
      |-> ##[1:4] op_mode_o == `OP_OFF)
      else $error("fault did not stop converter");
   off_quiet_a: assert property (op_mode_o == `OP_OFF |-> !lowside_en_o && !switch_pulse_o)
      else $error("switching while off");
   pulse_tick_a: assert property (switch_pulse_o |-> $past(sw_tick_i))
      else $error("pulse not on switching tick");
   forced_pwm_operation_ccm_a: assert property (sync_high_s ##0 !$past(ramp_active_o)
      |-> op_mode_o == `OP_CCM)
      else $error("pin high but not continuous");
   ramp_dcm_a: assert property (ramp_active_o && $past(ramp_active_o) && $past(load_level_i)
      == 2'h1 && op_mode_o != `OP_OFF |-> op_mode_o == `OP_DCM)
      else $error("ramp not in discontinuous mode");
   ramp_len_a: assert property ($fell(ramp_active_o) |-> ramp_cnt_q == RAMP_CYC0 ||
      ramp_cnt_q == RAMP_CYC1 || ramp_cnt_q == RAMP_CYC2 || ramp_cnt_q == RAMP_CYC3)
      else $error("ramp length not a listed time");
   setpt_hold_a: assert property (ramp_active_o && $past(ramp_active_o)
      |-> $stable(active_setpoint_o) && $stable(active_span_o))
      else $error("setting changed during ramp");
endmodule
bind buck_seq_ctrl buck_seq_chk #(
   .RAMP_CYC0(RAMP_CYC0),
   .RAMP_CYC1(RAMP_CYC1),
   .RAMP_CYC2(RAMP_CYC2),
   .RAMP_CYC3(RAMP_CYC3)
) u_chk (.clk_sys_i, .rst_i, .reg_rd_i, .reg_rdata_o, .en_pin_oe_o, .mode_sync_pin_i,
   .thermal_fault_i, .overvolt_fault_i, .sw_tick_i, .load_level_i, .ref_enable_o, .op_mode_o,
   .switch_pulse_o, .lowside_en_o, .ramp_active_o, .active_setpoint_o, .active_span_o);

// File: verif/en_line_peer.sv
module en_line_peer (
   input  logic dut_oe_i,
   input  logic host_low_i,
   input  logic peer_init_i,
   input  logic peer_fault_i,
   output logic en_line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // Shared enable line
   // ********************
   // Pull-up: a released line reads high, never a stale level
   // Peer keeps standalone at 0, so init and faults pull low
   assign en_line_o = !(dut_oe_i || host_low_i || peer_init_i || peer_fault_i);
endmodule

// File: verif/test_buck_seq_ctrl.sv
`include "buck_seq_map.vh"
module test_buck_seq_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // Signals
   // ********************
   logic       clk_sys_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, mode_sync_pin_i = 0;
   logic       clkout_strap_pin_i = 1, ref_ready_i = 0, thermal_fault_i = 0;
   logic       overvolt_fault_i = 0, sw_tick_i = 0, load_release_i = 0, ramp_above_out_i = 1;
   logic       host_low_i = 1, peer_init_i = 1, peer_fault_i = 0, en_pin_i, en_pin_o, pfm_demand_i;
   logic       en_pin_oe_o, ref_enable_o, clkout_sel_o, switch_pulse_o, lowside_en_o;
   logic       ramp_active_o;
   logic [2:0] reg_addr_i = 0;
   logic [7:0] reg_wdata_i = 0, reg_rdata_o, active_setpoint_o;
   logic [1:0] setpoint_strap_pin_i = 2, frequency_strap_pin_i = 1, load_level_i = 2, tick_q = 0;
   logic [1:0] freq_sel_o, op_mode_o, active_span_o;
   int         mismatches = 0, n_checks = 0;
   // Short ramps keep the run small; ascending like the real times
   int         rtab [4] = '{20, 30, 40, 80};
   // Entries: pin, forced bit, load, expected mode
   logic [5:0] mtab [5] = '{6'b0_0_10_01, 6'b0_0_01_10, 6'b0_0_00_11, 6'b0_1_00_01, 6'b1_0_00_01};
   assign pfm_demand_i = sw_tick_i;
   buck_seq_ctrl #(.RAMP_CYC0(20), .RAMP_CYC1(30), .RAMP_CYC2(40), .RAMP_CYC3(80),
      .EN_DELAY_CYC(5), .SYNC_WIN_CYC(8)) i_dut (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .en_pin_i, .en_pin_o, .en_pin_oe_o, .mode_sync_pin_i,
      .setpoint_strap_pin_i, .frequency_strap_pin_i, .clkout_strap_pin_i, .ref_ready_i,
      .thermal_fault_i, .overvolt_fault_i, .sw_tick_i, .load_level_i, .pfm_demand_i,
      .load_release_i, .ramp_above_out_i, .ref_enable_o, .freq_sel_o, .clkout_sel_o, .op_mode_o,
      .switch_pulse_o, .lowside_en_o, .ramp_active_o, .active_setpoint_o, .active_span_o);
   en_line_peer i_peer (.dut_oe_i(en_pin_oe_o), .host_low_i, .peer_init_i, .peer_fault_i,
      .en_line_o(en_pin_i));
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      tick_q <= tick_q + 2'h1;
      sw_tick_i <= (tick_q == 2'h3);
   end
   // ********************
   // Tasks
   // ********************
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string w);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 chk(w, reg_rdata_o, e);
   endtask
   task automatic wait_ramp(input logic v);
      for (int i = 0; i < 300 && ramp_active_o !== v; i++) cyc(1);
   endtask
   task automatic ramp_len(output int n);
      n = 0;
      wait_ramp(1'b1);
      while (ramp_active_o === 1'b1 && n < 200) begin
         n++;
         cyc(1);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge clk_sys_i);
      mismatches++;
      $display("ERROR watchdog expired");
      final_report();
   end
   // ********************
   // Tests
   // ********************
   initial begin
      int n;
      int k;
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      cyc(4);
      chk("init pulldown", en_pin_oe_o, 1);
      chk("pin drive level", en_pin_o, 0);
      wr(3'h3, 8'h01);
      rchk(3'h3, 8'h00, "early read");
      @(posedge clk_sys_i) ref_ready_i <= 1'b1;
      cyc(8);
      chk("ready release", en_pin_oe_o, 0);
      rchk(3'h3, 8'h00, "early write dropped");
      rchk(3'h0, 8'h5f, "strap setpoint");
      rchk(3'h1, 8'h04, "ctrl1 reset");
      rchk(3'h2, 8'h02, "ctrl2 reset");
      rchk(3'h5, 8'h00, "unmapped");
      chk("freq strap", freq_sel_o, 1);
      chk("clkout strap", clkout_sel_o, 1);
      wr(3'h1, 8'hff);
      rchk(3'h1, 8'h0f, "idle write");
      wr(3'h1, 8'h04);
      @(posedge clk_sys_i) host_low_i <= 1'b0;
      cyc(20);
      chk("peer holds off", ramp_active_o, 0);
      @(posedge clk_sys_i) peer_init_i <= 1'b0;
      ramp_len(n);
      chk("default ramp", 8'(n), 8'(rtab[2]));
      @(posedge clk_sys_i) host_low_i <= 1'b1;
      cyc(6);
      chk("enable low off", op_mode_o, `OP_OFF);
      rchk(3'h4, 8'h01, "status idle");
      for (int c = 0; c < 4; c++) begin
         wr(3'h2, 8'(c));
         @(posedge clk_sys_i) host_low_i <= 1'b0;
         ramp_len(n);
         chk("ramp time", 8'(n), 8'(rtab[c]));
         @(posedge clk_sys_i) host_low_i <= 1'b1;
         cyc(6);
      end
      wr(3'h2, 8'h03);
      @(posedge clk_sys_i);
      ramp_above_out_i <= 1'b0;
      mode_sync_pin_i <= 1'b1;
      load_level_i <= 2'h1;
      host_low_i <= 1'b0;
      wait_ramp(1'b1);
      cyc(3);
      chk("prebias idle", op_mode_o, `OP_OFF);
      wr(3'h0, 8'h33);
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h00);
      chk("held setpoint", active_setpoint_o, 8'h5f);
      chk("held span", active_span_o, 2);
      @(posedge clk_sys_i) ramp_above_out_i <= 1'b1;
      cyc(3);
      chk("ramp mode", op_mode_o, `OP_DCM);
      wait_ramp(1'b0);
      cyc(2);
      chk("new setpoint", active_setpoint_o, 8'h33);
      chk("new span", active_span_o, 0);
      foreach (mtab[i]) begin
         wr(3'h1, {7'h00, mtab[i][4]});
         @(posedge clk_sys_i);
         mode_sync_pin_i <= mtab[i][5];
         load_level_i <= mtab[i][3:2];
         cyc(6);
         chk("mode", op_mode_o, mtab[i][1:0]);
      end
      wr(3'h1, 8'h08);
      @(posedge clk_sys_i);
      mode_sync_pin_i <= 1'b0;
      load_level_i <= 2'h2;
      cyc(8);
      @(posedge clk_sys_i) load_release_i <= 1'b1;
      k = 0;
      n = 0;
      for (int i = 0; i < 100 && !(k && lowside_en_o); i++) begin
         cyc(1);
         if (!lowside_en_o) k = 1;
         if (!lowside_en_o && switch_pulse_o) n++;
      end
      chk("release cycles", 8'(n), 8'd6);
      @(posedge clk_sys_i) peer_fault_i <= 1'b1;
      cyc(5);
      chk("peer fault off", op_mode_o, `OP_OFF);
      @(posedge clk_sys_i) peer_fault_i <= 1'b0;
      @(posedge clk_sys_i) thermal_fault_i <= 1'b1;
      cyc(2);
      chk("fault pulldown", en_pin_oe_o, 1);
      cyc(3);
      chk("fault off", op_mode_o, `OP_OFF);
      @(posedge clk_sys_i) thermal_fault_i <= 1'b0;
      cyc(4);
      wr(3'h3, 8'h01);
      @(posedge clk_sys_i) overvolt_fault_i <= 1'b1;
      cyc(5);
      chk("standalone fault", en_pin_oe_o, 0);
      chk("standalone off", op_mode_o, `OP_OFF);
      @(posedge clk_sys_i) overvolt_fault_i <= 1'b0;
      @(posedge clk_sys_i) rst_i <= 1'b1;
      setpoint_strap_pin_i <= 2'h3;
      frequency_strap_pin_i <= 2'h2;
      clkout_strap_pin_i <= 1'b0;
      cyc(3);
      chk("reset pulldown", en_pin_oe_o, 1);
      @(posedge clk_sys_i) rst_i <= 1'b0;
      cyc(8);
      rchk(3'h3, 8'h00, "standalone cleared");
      rchk(3'h0, 8'h24, "strap setpoint again");
      chk("freq strap again", freq_sel_o, 2);
      chk("clkout strap again", clkout_sel_o, 0);
      final_report();
   end
endmodule
